// ---- logic/four_digit_mux_clock.sv ----
`timescale 1ns/100ps
module four_digit_mux_clock (
  input wire logic mclk,
  input wire logic reset,
  input wire logic line_clk_pin,
  input wire logic mux_osc_pin,
  input wire logic [6:0] pad_in,
  output logic [6:0] pad_out,
  output logic [6:0] pad_oe,
  output logic [3:0] digit_sel_n,
  output logic strobe_n,
  output logic counting
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [1:0] line_sync_ff;
  logic [1:0] osc_sync_ff;
  logic line_prev_ff;
  logic osc_prev_ff;
  logic [6:0] pad_sync1_ff;
  logic [6:0] pad_sync2_ff;
  logic [4:0] tick_ff;
  clock_pkg::slot_e slot_ff;
  clock_pkg::sw_s sw_ff;
  logic [5:0] line_cnt_ff;
  logic [5:0] sec_cnt_ff;
  clock_pkg::time_s time_ff;
  logic run_ff;
  logic [6:0] pad_out_ff;
  logic [6:0] pad_oe_ff;
  logic [3:0] digit_sel_n_ff;
  logic strobe_n_ff;

  logic line_edge_w;
  logic osc_edge_w;
  logic slot_end_w;
  logic blank_w;
  logic strobe_slot_w;
  logic sample_w;
  clock_pkg::sw_s sw_w;
  clock_pkg::slot_e nxt_slot;
  logic [4:0] nxt_tick;
  logic [5:0] div_last_w;
  logic sec_tick_w;
  logic set_any_w;
  logic inc_min_w;
  logic min_wrap_w;
  logic inc_hour_w;
  logic [5:0] nxt_line_cnt;
  logic [5:0] nxt_sec_cnt;
  clock_pkg::time_s nxt_time;
  logic nxt_run;
  logic [4:0] disp_h_w;
  logic [7:0] min_bcd_w;
  logic [7:0] hr_bcd_w;
  logic [3:0] digit_w [4];
  logic [3:0] cur_digit_w;
  logic suppress_w;
  logic [6:0] pat_w;
  logic [6:0] bcd_bus_w;
  logic [6:0] data_w;
  logic [6:0] off_w;
  logic [6:0] nxt_pad_out;
  logic [6:0] nxt_pad_oe;
  logic [3:0] nxt_digit_sel_n;
  logic nxt_strobe_n;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Binary 0..59 to two BCD digits, tens in the upper nibble
  function automatic logic [7:0] to_bcd(input logic [5:0] v);
    logic [5:0] t;
    logic [5:0] u;
    t = v / 6'h0a;
    u = v - t * 6'h0a;
    to_bcd = {t[3:0], u[3:0]};
  endfunction : to_bcd

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Both clocks and the shared pins are asynchronous to mclk
  always_ff @(posedge mclk) begin
    if (reset) begin
      line_sync_ff <= 2'h0;
      osc_sync_ff <= 2'h0;
      line_prev_ff <= 1'b0;
      osc_prev_ff <= 1'b0;
      pad_sync1_ff <= 7'h7f;
      pad_sync2_ff <= 7'h7f;
    end else begin
      line_sync_ff <= {line_sync_ff[0], line_clk_pin};
      osc_sync_ff <= {osc_sync_ff[0], mux_osc_pin};
      line_prev_ff <= line_sync_ff[1];
      osc_prev_ff <= osc_sync_ff[1];
      pad_sync1_ff <= pad_in;
      pad_sync2_ff <= pad_sync1_ff;
    end
  end

  // Rising edges seen only after the second stage
  assign line_edge_w = line_sync_ff[1] & ~line_prev_ff;
  assign osc_edge_w = osc_sync_ff[1] & ~osc_prev_ff;

  // ----------------------------------------
  // Multiplex sequencer
  // ----------------------------------------
  // Twenty oscillator edges make one slot
  assign slot_end_w = osc_edge_w && (tick_ff == clock_pkg::TICK_LAST); // RULE2
  assign nxt_tick = slot_end_w ? 5'h00 : (osc_edge_w ? tick_ff + 5'h01 : tick_ff); // RULE2
  assign nxt_slot = (slot_ff == clock_pkg::SLOT_STROBE) ? clock_pkg::SLOT_MIN_U
                  : clock_pkg::slot_e'(slot_ff + 3'h1); // RULE1
  // First quarter of every slot is dark
  assign blank_w = tick_ff < clock_pkg::BLANK_TICKS; // RULE5
  assign strobe_slot_w = slot_ff == clock_pkg::SLOT_STROBE;

  always_ff @(posedge mclk) begin
    if (reset) begin
      tick_ff <= 5'h00;
      slot_ff <= clock_pkg::SLOT_MIN_U;
    end else begin
      tick_ff <= nxt_tick;
      if (slot_end_w) begin
        slot_ff <= nxt_slot; // RULE1
      end
    end
  end

  // ----------------------------------------
  // Control switch sampling
  // ----------------------------------------
  // A switch closed to strobe reads low; an open pin is pulled high.
  // Sampling on the last tick comes fifteen ticks after the strobe falls and just before it rises.
  assign sample_w = strobe_slot_w && slot_end_w; // RULE3
  assign sw_w = '{set_hours: ~pad_sync2_ff[clock_pkg::PIN_SET_HOURS],
                  set_min: ~pad_sync2_ff[clock_pkg::PIN_SET_MIN],
                  clr: ~pad_sync2_ff[clock_pkg::PIN_CLEAR],
                  compl: ~pad_sync2_ff[clock_pkg::PIN_COMPL],
                  fmt24: ~pad_sync2_ff[clock_pkg::PIN_FMT_SEL],
                  hz60: ~pad_sync2_ff[clock_pkg::PIN_HZ_SEL],
                  bcd: ~pad_sync2_ff[clock_pkg::PIN_BCD_SEL]};

  // Options and keys hold until the next strobe slot
  always_ff @(posedge mclk) begin
    if (reset) begin
      sw_ff <= clock_pkg::SW_RESET;
    end else if (sample_w) begin
      sw_ff <= sw_w; // RULE3
    end
  end

  // ----------------------------------------
  // Line divider and seconds
  // ----------------------------------------
  assign div_last_w = sw_ff.hz60 ? clock_pkg::DIV60_LAST : clock_pkg::DIV50_LAST; // RULE14
  assign sec_tick_w = line_edge_w && (line_cnt_ff >= div_last_w);
  assign nxt_line_cnt = sec_tick_w ? 6'h00 : (line_edge_w ? line_cnt_ff + 6'h01 : line_cnt_ff);
  assign set_any_w = sw_ff.set_hours | sw_ff.set_min;
  // Seconds restart while setting so the next minute is a full one
  assign nxt_sec_cnt = (sw_ff.clr || set_any_w || !run_ff) ? 6'h00
                     : !sec_tick_w ? sec_cnt_ff
                     : (sec_cnt_ff == clock_pkg::SEC_LAST) ? 6'h00 : sec_cnt_ff + 6'h01;

  // ----------------------------------------
  // Time counters
  // ----------------------------------------
  // Set keys step once per second; a minute wrap carries into hours
  assign inc_min_w = sec_tick_w && (sw_ff.set_min ||
                     (run_ff && !set_any_w && sec_cnt_ff == clock_pkg::SEC_LAST)); // RULE10
  assign min_wrap_w = inc_min_w && (time_ff.minutes == clock_pkg::MIN_LAST); // RULE18
  assign inc_hour_w = (sec_tick_w && sw_ff.set_hours) || min_wrap_w; // RULE9
  assign nxt_time.minutes = sw_ff.clr ? 6'h00 // RULE11
                          : min_wrap_w ? 6'h00
                          : inc_min_w ? time_ff.minutes + 6'h01 : time_ff.minutes;
  assign nxt_time.hours = sw_ff.clr ? 5'h00 // RULE11
                        : !inc_hour_w ? time_ff.hours
                        : (time_ff.hours == clock_pkg::HOUR_LAST) ? 5'h00 : time_ff.hours + 5'h01; // RULE18
  // Counting stays stopped from power-up until a set key is used
  assign nxt_run = run_ff | set_any_w; // RULE17

  always_ff @(posedge mclk) begin
    if (reset) begin
      line_cnt_ff <= 6'h00;
      sec_cnt_ff <= 6'h00;
      time_ff <= clock_pkg::TIME_RESET; // RULE17
      run_ff <= 1'b0;
    end else begin
      line_cnt_ff <= nxt_line_cnt;
      sec_cnt_ff <= nxt_sec_cnt;
      time_ff <= nxt_time;
      run_ff <= nxt_run;
    end
  end

  // ----------------------------------------
  // Digit selection
  // ----------------------------------------
  // Hours count 0..23 inside; 12 hour mode shows 1..12
  assign disp_h_w = sw_ff.fmt24 ? time_ff.hours // RULE13
                  : (time_ff.hours == 5'h00) ? clock_pkg::HOUR_NOON
                  : (time_ff.hours > clock_pkg::HOUR_NOON) ? time_ff.hours - clock_pkg::HOUR_NOON
                  : time_ff.hours; // RULE18
  assign min_bcd_w = to_bcd(time_ff.minutes);
  assign hr_bcd_w = to_bcd({1'b0, disp_h_w});
  assign digit_w[0] = min_bcd_w[3:0]; // RULE19
  assign digit_w[1] = min_bcd_w[7:4];
  assign digit_w[2] = hr_bcd_w[3:0];
  assign digit_w[3] = hr_bcd_w[7:4]; // RULE19
  assign cur_digit_w = digit_w[slot_ff[1:0]];
  // BCD data keeps every code, so only the segment display is suppressed
  assign suppress_w = !sw_ff.fmt24 && !sw_ff.bcd && (slot_ff == clock_pkg::SLOT_HR_T)
                    && (cur_digit_w == 4'h0); // RULE16

  seg_encode u_seg_encode (
    .digit(cur_digit_w),
    .pattern(pat_w)
  );

  // BCD bits sit on the pins that also carry the set keys, the reset key and the complement switch
  always_comb begin
    bcd_bus_w = 7'h00;
    bcd_bus_w[clock_pkg::PIN_BCD0] = cur_digit_w[0];
    bcd_bus_w[clock_pkg::PIN_BCD1] = cur_digit_w[1];
    bcd_bus_w[clock_pkg::PIN_BCD2] = cur_digit_w[2];
    bcd_bus_w[clock_pkg::PIN_BCD3] = cur_digit_w[3];
  end

  // ----------------------------------------
  // Output drive
  // ----------------------------------------
  // Lit segment is low, BCD one is high; complement flips both
  assign data_w = sw_ff.bcd ? (sw_ff.compl ? ~bcd_bus_w : bcd_bus_w) // RULE6 RULE15 RULE12
                : (sw_ff.compl ? pat_w : ~pat_w); // RULE4 RULE12
  assign off_w = sw_ff.compl ? 7'h00 : 7'h7f;
  assign nxt_pad_out = (blank_w || strobe_slot_w || suppress_w) ? off_w : data_w; // RULE5
  // Pins float through the whole strobe slot so switches can pull them
  assign nxt_pad_oe = strobe_slot_w ? 7'h00 : 7'h7f; // RULE3
  assign nxt_digit_sel_n = (blank_w || strobe_slot_w) ? 4'hf
                         : ~(4'h1 << slot_ff[1:0]); // RULE7 RULE5
  assign nxt_strobe_n = !(strobe_slot_w && !blank_w); // RULE8

  always_ff @(posedge mclk) begin
    if (reset) begin
      pad_out_ff <= 7'h7f;
      pad_oe_ff <= 7'h00;
      digit_sel_n_ff <= 4'hf;
      strobe_n_ff <= 1'b1;
    end else begin
      pad_out_ff <= nxt_pad_out;
      pad_oe_ff <= nxt_pad_oe;
      digit_sel_n_ff <= nxt_digit_sel_n;
      strobe_n_ff <= nxt_strobe_n;
    end
  end

  assign pad_out = pad_out_ff;
  assign pad_oe = pad_oe_ff;
  assign digit_sel_n = digit_sel_n_ff;
  assign strobe_n = strobe_n_ff;
  assign counting = run_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  slot_order_a: // RULE1
  assert property (slot_end_w && strobe_slot_w |=> slot_ff == clock_pkg::SLOT_MIN_U)
    else $error("slot sequence did not return to first digit");

  slot_rate_a: // RULE2
  assert property (osc_edge_w && tick_ff != clock_pkg::TICK_LAST |=> $stable(slot_ff))
    else $error("slot changed before twenty oscillator edges");

  pad_release_a: // RULE3
  assert property (strobe_slot_w |=> pad_oe == 7'h00)
    else $error("shared pins driven during strobe slot");

  seg_polarity_a: // RULE4
  assert property (!blank_w && !strobe_slot_w && !sw_ff.bcd && !sw_ff.compl && !suppress_w
                   |=> pad_out == ~$past(pat_w))
    else $error("segment pattern not shown active low");

  blank_quarter_a: // RULE5
  assert property (blank_w |=> digit_sel_n == 4'hf && strobe_n && pad_out == $past(off_w))
    else $error("outputs not blank in first quarter of slot");

  digit_select_a: // RULE7
  assert property (slot_ff == clock_pkg::SLOT_HR_U && !blank_w |=> digit_sel_n == 4'hb)
    else $error("wrong digit select for third slot");

  strobe_low_a: // RULE8
  assert property (strobe_slot_w && !blank_w |=> !strobe_n ##0 digit_sel_n == 4'hf)
    else $error("strobe not low in fifth slot");

  set_hours_a: // RULE9
  assert property (sec_tick_w && sw_ff.set_hours && !sw_ff.clr && time_ff.hours < clock_pkg::HOUR_LAST
                   |=> time_ff.hours == $past(time_ff.hours) + 5'h01)
    else $error("set hours did not advance hours");

  clear_time_a: // RULE11
  assert property (sw_ff.clr |=> time_ff == clock_pkg::TIME_RESET)
    else $error("reset switch did not clear time");

  hold_stopped_a: // RULE17
  assert property (!run_ff && !set_any_w && !sw_ff.clr |=> $stable(time_ff))
    else $error("time moved before being set");

  range_limit_a: // RULE18
  assert property (time_ff.hours <= clock_pkg::HOUR_LAST && time_ff.minutes <= clock_pkg::MIN_LAST)
    else $error("time count out of range");

  set_minutes_a: // RULE10
  assert property (sec_tick_w && sw_ff.set_min && !sw_ff.clr && time_ff.minutes < clock_pkg::MIN_LAST
                   |=> time_ff.minutes == $past(time_ff.minutes) + 6'h01)
    else $error("set minutes did not advance minutes");

  minute_carry_a: // RULE18
  assert property (min_wrap_w && !sw_ff.clr |=> time_ff.minutes == 6'h00)
    else $error("minutes did not wrap to zero");

  hour_wrap_a: // RULE18
  assert property (inc_hour_w && !sw_ff.clr && time_ff.hours == clock_pkg::HOUR_LAST
                   |=> time_ff.hours == 5'h00)
    else $error("hours did not wrap to zero");

  bcd_polarity_a: // RULE6
  assert property (!blank_w && !strobe_slot_w && sw_ff.bcd && !sw_ff.compl |=> pad_out == $past(bcd_bus_w))
    else $error("BCD value not shown true high");

  zero_blank_a: // RULE16
  assert property (suppress_w && !blank_w |=> pad_out == $past(off_w))
    else $error("leading hour zero not blanked");

  strobe_sample_c: cover property (sample_w && sw_w.set_min);
  minute_wrap_c: cover property (min_wrap_w);
  bcd_24h_c: cover property (sw_ff.bcd && sw_ff.fmt24 && !blank_w);

endmodule : four_digit_mux_clock

// ---- logic/clock_pkg.sv ----
// Notes on behaviour
// RULE1: Five multiplex slots: four digit slots, then one strobe slot for control inputs.
// RULE2: Slot rate is one twentieth of the multiplex clock frequency.
// RULE3: Shared pins drive data in slots one to four, sampled in slot five.
// RULE4: Seven-segment mode shows segment patterns; lit segment is low at normal polarity.
// RULE5: Segment and digit-select outputs blank for a quarter of each digit time.
// RULE6: BCD mode shows four-bit codes; zero is all low at normal polarity.
// RULE7: Four digit-select outputs go low one after another, one per digit slot.
// RULE8: Strobe output goes low during the fifth slot to enable the keyboard.
// RULE9: Set-hours low at strobe advances hours by one per second.
// RULE10: Set-minutes low at strobe advances minutes per second, hours per minute.
// RULE11: Reset input low at strobe clears the whole time to zero.
// RULE12: Complement open keeps normal polarity; tied to strobe inverts all data outputs.
// RULE13: Hour-format open gives 12 hour mode; tied to strobe gives 24 hour.
// RULE14: Line select open divides for 50 Hz; tied to strobe for 60 Hz.
// RULE15: Coding select open gives seven-segment; tied to strobe gives BCD.
// RULE16: In 12 hour mode a leading zero in tens of hours is blanked; the code blanks it in seven-segment mode only, BCD mode keeps the zero code.
// RULE17: After power-up time is zero and counting waits until time is set.
// RULE18: Hours show 1..12 or 0..23; minutes wrap 59 to 0 with carry.
// RULE19: First digit slot carries minute units, fourth slot carries hour tens.
package clock_pkg;

  // ----------------------------------------
  // Multiplex timing
  // ----------------------------------------
  localparam logic [4:0] TICK_LAST = 5'h13;
  localparam logic [4:0] BLANK_TICKS = 5'h05;

  // ----------------------------------------
  // Time keeping counts
  // ----------------------------------------
  localparam logic [5:0] DIV50_LAST = 6'h31;
  localparam logic [5:0] DIV60_LAST = 6'h3b;
  localparam logic [5:0] SEC_LAST = 6'h3b;
  localparam logic [5:0] MIN_LAST = 6'h3b;
  localparam logic [4:0] HOUR_LAST = 5'h17;
  localparam logic [4:0] HOUR_NOON = 5'h0c;

  // ----------------------------------------
  // Shared pin positions
  // ----------------------------------------
  localparam int PIN_SET_HOURS = 0;
  localparam int PIN_BCD_SEL = 1;
  localparam int PIN_HZ_SEL = 2;
  localparam int PIN_FMT_SEL = 3;
  localparam int PIN_COMPL = 4;
  localparam int PIN_CLEAR = 5;
  localparam int PIN_SET_MIN = 6;
  localparam int PIN_BCD0 = 0;
  localparam int PIN_BCD1 = 6;
  localparam int PIN_BCD2 = 5;
  localparam int PIN_BCD3 = 4;

  typedef enum logic [2:0] {
    SLOT_MIN_U,
    SLOT_MIN_T,
    SLOT_HR_U,
    SLOT_HR_T,
    SLOT_STROBE
  } slot_e;

  // Control switches, decoded to active high
  typedef struct packed {
    logic set_hours;
    logic set_min;
    logic clr;
    logic compl;
    logic fmt24;
    logic hz60;
    logic bcd;
  } sw_s;

  typedef struct packed {
    logic [4:0] hours;
    logic [5:0] minutes;
  } time_s;

  localparam sw_s SW_RESET = '0;
  localparam time_s TIME_RESET = '0;

endpackage : clock_pkg

// ---- logic/seg_encode.sv ----
`timescale 1ns/100ps
// Digit to segment pattern, bit 0 is segment A, 1 means lit
module seg_encode (
  input wire logic [3:0] digit,
  output logic [6:0] pattern
);

  // Codes above nine cannot come from the counters; they show dark
  always_comb begin
    unique case (digit)
      4'h0: pattern = 7'h3f;
      4'h1: pattern = 7'h06;
      4'h2: pattern = 7'h5b;
      4'h3: pattern = 7'h4f;
      4'h4: pattern = 7'h66;
      4'h5: pattern = 7'h6d;
      4'h6: pattern = 7'h7d;
      4'h7: pattern = 7'h07;
      4'h8: pattern = 7'h7f;
      4'h9: pattern = 7'h6f;
      default: pattern = 7'h00;
    endcase
  end

endmodule : seg_encode

// ---- tb/display_keys.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// Display panel and control keyboard
// ----------------------------------------
module display_keys (
  input wire logic mclk,
  input wire logic [6:0] pad_out,
  input wire logic [6:0] pad_oe,
  input wire logic [3:0] digit_sel_n,
  input wire logic strobe_n,
  input wire logic [6:0] key_closed,
  input wire logic [6:0] diode_tied,
  output logic [6:0] pad_in,
  output logic [3:0][6:0] shown_ff
);
  logic [6:0] pull_low;

  // Keys and diodes only reach a pin while the strobe line is low
  assign pull_low = {7{~strobe_n}} & (key_closed | diode_tied);
  // A closed contact shorts the pin even if the chip drives it; otherwise the chip's level wins, or the pull-up when released
  assign pad_in = ~pull_low & (~pad_oe | pad_out);

  // Each digit keeps what it last showed while selected
  always_ff @(posedge mclk) begin
    for (int k = 0; k < 4; k++) begin
      if (!digit_sel_n[k]) begin
        shown_ff[k] <= pad_out;
      end
    end
  end
endmodule : display_keys

// ---- tb/tb_four_digit_mux_clock.sv ----
`timescale 1ns/100ps
module tb_four_digit_mux_clock;
  localparam logic [6:0] SEGS [6] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d};
  localparam logic [4:0] SLOTS [10] = '{5'h1f, 5'h1d, 5'h1f, 5'h1b, 5'h1f, 5'h17, 5'h1f, 5'h0f, 5'h1f, 5'h1e};
  logic mclk;
  logic reset;
  logic line_clk_pin;
  logic mux_osc_pin;
  logic [6:0] pad_in;
  logic [6:0] pad_out;
  logic [6:0] pad_oe;
  logic [3:0] digit_sel_n;
  logic strobe_n;
  logic counting;
  logic [6:0] key_closed;
  logic [6:0] diode_tied;
  logic [3:0][6:0] shown;
  logic bcd_m;
  logic inv_m;
  logic h24_m;
  logic [4:0] v;
  logic [31:0] n;
  logic [6:0] prev;
  int sec;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;

  four_digit_mux_clock dut (.mclk(mclk), .reset(reset), .line_clk_pin(line_clk_pin), .mux_osc_pin(mux_osc_pin),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .digit_sel_n(digit_sel_n), .strobe_n(strobe_n),
    .counting(counting));
  display_keys panel (.mclk(mclk), .pad_out(pad_out), .pad_oe(pad_oe), .digit_sel_n(digit_sel_n),
    .strobe_n(strobe_n), .key_closed(key_closed), .diode_tied(diode_tied), .pad_in(pad_in), .shown_ff(shown));

  // ----------------------------------------
  // Clocks: 100 MHz system, 4-cycle multiplex, 20-cycle mains
  // ----------------------------------------
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  // Both pins toggle on falling system edges, so sync latency is fixed
  initial begin
    forever #20 mux_osc_pin = ~mux_osc_pin;
  end
  initial begin
    forever #100 line_clk_pin = ~line_clk_pin;
  end

  // Hang guard, about two thirds again the expected run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      $display("MISMATCH at %0t: run did not finish", $time);
      close_out();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Pin levels of one digit in the current output mode
  function automatic logic [6:0] pins(input int d, input logic off);
    logic [6:0] p;
    logic [3:0] b;
    b = 4'(d);
    p = bcd_m ? {b[1], b[2], b[3], 3'h0, b[0]} : (off ? 7'h00 : SEGS[d]);
    return (bcd_m ^ inv_m) ? p : ~p;
  endfunction : pins

  // Four slots, minute units first; only digits 0..5 are used, their shapes are unambiguous
  function automatic logic [27:0] face(input int h, input int m);
    int dh;
    dh = h24_m ? h : (h == 0 ? 12 : (h > 12 ? h - 12 : h));
    return {pins(dh / 10, !h24_m && dh < 10), pins(dh % 10, 1'h0), pins(m / 10, 1'h0), pins(m % 10, 1'h0)};
  endfunction : face

  // Cycles until the select and strobe lines next change
  task automatic next_change();
    logic [4:0] cur;
    cur = {strobe_n, digit_sel_n};
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while ({strobe_n, digit_sel_n} === cur && n < 1000);
    v = {strobe_n, digit_sel_n};
  endtask : next_change

  // Follow digit k through the first step and the given number more, then let the keys go.
  // A step shows within one frame, so the release reaches a strobe sample before the next second;
  // a fixed wait instead could let one more step slip in, depending on the frame phase.
  task automatic step_check(input int k, input int steps, input int h, input int m);
    int t0;
    int dt;
    t0 = 0;
    for (int j = 0; j <= steps; j++) begin
      for (int i = 0; i < 5000 && shown[k] === prev; i++) @(negedge mclk);
      prev = shown[k];
      if (j == 0) t0 = cyc;
    end
    key_closed = 7'h00;
    repeat (600) @(negedge mclk);
    // Step spacing is one second; display lag moves each sighting by under one frame
    dt = cyc - t0 - 600 - steps * sec;
    chk((dt >= -400 && dt <= 400) ? 32'h1 : 32'h0, 32'h1, "step rate");
    chk({4'h0, shown}, {4'h0, face(h, m)}, "face after setting");
  endtask : step_check

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    reset = 1'h1;
    line_clk_pin = 1'h0;
    mux_osc_pin = 1'h0;
    key_closed = 7'h00;
    diode_tied = 7'h00;
    bcd_m = 1'h0;
    inv_m = 1'h0;
    h24_m = 1'h0;
    sec = 1000;
    repeat (3) @(negedge mclk);
    reset = 1'h0;
    // Slot order and lengths: 15 mux edges shown, 5 blank
    for (int i = 0; i < 20 && v !== 5'h1e; i++) next_change();
    for (int i = 0; i < 10; i++) begin
      next_change();
      chk({27'h0, v}, {27'h0, SLOTS[i]}, "slot lines");
      chk(n, (i % 2 == 0) ? 32'h3c : 32'h14, "slot length");
      if (i % 2 == 1) chk({25'h0, pad_oe}, (v == 5'h0f) ? 32'h00 : 32'h7f, "pin direction");
    end
    $display("slot sequence test done");
    // Stopped at twelve o'clock until a set key is seen
    repeat (3000) @(negedge mclk);
    chk({31'h0, counting}, 32'h0, "running before set");
    chk({4'h0, shown}, {4'h0, face(0, 0)}, "power-up face");
    // Hours step once a second in 12 hour mode, tens blanked below ten
    prev = shown[2];
    key_closed[clock_pkg::PIN_SET_HOURS] = 1'h1;
    step_check(2, 3, 4, 0);
    key_closed = 7'h00;
    chk({31'h0, counting}, 32'h1, "running after set");
    repeat (2500) @(negedge mclk);
    chk({4'h0, shown}, {4'h0, face(4, 0)}, "set key released");
    $display("set hours test done");
    key_closed[clock_pkg::PIN_CLEAR] = 1'h1;
    repeat (1000) @(negedge mclk);
    chk({4'h0, shown}, {4'h0, face(0, 0)}, "cleared face");
    key_closed = 7'h00;
    $display("clear test done");
    // Diode options: BCD, complement, 24 hour, 60 Hz
    diode_tied[clock_pkg::PIN_BCD_SEL] = 1'h1;
    diode_tied[clock_pkg::PIN_COMPL] = 1'h1;
    diode_tied[clock_pkg::PIN_FMT_SEL] = 1'h1;
    diode_tied[clock_pkg::PIN_HZ_SEL] = 1'h1;
    bcd_m = 1'h1;
    inv_m = 1'h1;
    h24_m = 1'h1;
    sec = 1200;
    repeat (1000) @(negedge mclk);
    chk({4'h0, shown}, {4'h0, face(0, 0)}, "inverted BCD face");
    prev = shown[0];
    key_closed[clock_pkg::PIN_SET_MIN] = 1'h1;
    step_check(0, 4, 0, 5);
    key_closed = 7'h00;
    $display("option and set minutes test done");
    // Back to normal segments, hours past noon in 24 hour mode
    diode_tied[clock_pkg::PIN_BCD_SEL] = 1'h0;
    diode_tied[clock_pkg::PIN_COMPL] = 1'h0;
    bcd_m = 1'h0;
    inv_m = 1'h0;
    repeat (1000) @(negedge mclk);
    prev = shown[2];
    key_closed[clock_pkg::PIN_SET_HOURS] = 1'h1;
    step_check(2, 12, 13, 5);
    key_closed = 7'h00;
    $display("24 hour test done");
    close_out();
  end
endmodule : tb_four_digit_mux_clock
